// ---- core/lip_pkg.sv ----
/*
  Shared constants of the LED intensity PWM block: register offsets, field
  positions, reset values and timebase figures.
  Assumes a 125 MHz system clock; used by package-qualified names only.
*/
package lip_pkg;
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned PWM_OSC_HZ   = 32_000;
  // one pwm step per oscillator tick, rounded down to whole clock cycles
  localparam int unsigned PWM_STEP_CYC = CLK_HZ / PWM_OSC_HZ;

  localparam int unsigned NUM_OUT      = 17;
  localparam int unsigned SPARE_IDX    = 16;
  localparam int unsigned NUM_IND_REG  = 8;
  localparam int unsigned NUM_SLOTS    = 15;
  localparam int unsigned NUM_SUBS     = 16;

  localparam logic [7:0] ADDR_MASTER   = 8'h0e;
  localparam logic [7:0] ADDR_IND_LO   = 8'h10;
  localparam logic [7:0] ADDR_IND_HI   = 8'h17;

  localparam int unsigned MASTER_MSB   = 7;
  localparam int unsigned MASTER_LSB   = 4;
  localparam int unsigned GLOBAL_MSB   = 3;
  localparam int unsigned GLOBAL_LSB   = 0;
  localparam int unsigned IND_HI_LSB   = 4;

  localparam logic [7:0] MASTER_RESET  = 8'h00;
  localparam logic [7:0] IND_RESET     = 8'h00;
  localparam logic [3:0] CODE_STATIC   = 4'hf;
  localparam logic [3:0] SUB_LAST      = 4'hf;
  localparam logic [3:0] SLOT_LAST     = 4'he;
endpackage

// ---- core/lip_tick_if.sv ----
/*
  Timebase position carried from the PWM timebase to the output logic.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface lip_tick_if;
  logic       step;
  logic       pstart;
  logic [3:0] sub;
  logic [3:0] slot;
  modport src (output step, output pstart, output sub, output slot);
  modport snk (input step, input pstart, input sub, input slot);
endinterface

// ---- core/lip_timebase.sv ----
/*
  PWM timebase: divides the system clock into pwm steps and counts
  16 sub-cycles inside each of 15 master timeslots.
  Assumes run_i comes from logic on the same clock.
*/
`timescale 1ns/10ps
module lip_timebase #(
  parameter int unsigned STEP_CYC = lip_pkg::PWM_STEP_CYC
) (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  lip_tick_if.src   tk
);
  typedef struct packed {
    logic [11:0] div;
    logic        step;
    logic        pstart;
    logic [3:0]  sub;
    logic [3:0]  slot;
  } lip_tb_s;

  localparam logic [11:0] DIV_LAST = 12'(STEP_CYC - 1);

  lip_tb_s q;
  lip_tb_s next_q;

  always_comb begin
    next_q        = q;
    next_q.step   = 1'b0;
    next_q.pstart = 1'b0;
    if (!run_i) begin
      // idle while run_i is low (master nibble zero, every output static), so no stray ticks
      next_q = '0;
    end else if (q.div == DIV_LAST) begin
      next_q.div  = 12'h000;
      next_q.step = 1'b1;
      if (q.sub == lip_pkg::SUB_LAST) begin
        next_q.sub  = 4'h0;
        next_q.slot = (q.slot == lip_pkg::SLOT_LAST) ? 4'h0 : q.slot + 4'h1;
        next_q.pstart = (q.slot == lip_pkg::SLOT_LAST);
      end else begin
        next_q.sub = q.sub + 4'h1;
      end
    end else begin
      next_q.div = q.div + 12'h001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tk.step   = q.step;
  assign tk.pstart = q.pstart;
  assign tk.sub    = q.sub;
  assign tk.slot   = q.slot;
endmodule

// ---- core/lip_pwm_ctrl.sv ----
/*
  LED intensity PWM with global/individual selection. Holds the master and
  global intensity register and the individual intensity registers, and
  drives the open-drain output enables of 17 ports.
  Assumes register writes come from the serial interface on the same clock,
  the global flag comes from the configuration register, and phase_bits_i
  carries the blink phase register bit currently selected for each port.
*/
`timescale 1ns/10ps
module lip_pwm_ctrl #(
  parameter int unsigned STEP_CYC = lip_pkg::PWM_STEP_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        global_en_i,
  input  wire logic [16:0] phase_bits_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             pwm_active_o,
  output logic      [16:0] pin_out_o,
  output logic      [16:0] pin_oe_o
);
  typedef struct packed {
    logic [7:0]      mreg;
    logic [7:0][7:0] ind;
    logic [7:0]      eff_m;
    logic [7:0][7:0] eff_ind;
    logic            eff_g;
    logic [7:0]      rdata;
    logic            active;
    logic [16:0]     oe;
  } lip_ctl_s;

  lip_ctl_s q;
  lip_ctl_s next_q;
  lip_tick_if tk ();

  // any nonzero master nibble means pwm is on for every port whose code is not f
  function automatic logic master_runs(input logic [7:0] m);
    return m[lip_pkg::MASTER_MSB:lip_pkg::MASTER_LSB] != 4'h0;
  endfunction

  function automatic logic ind_addr(input logic [7:0] a);
    return (a >= lip_pkg::ADDR_IND_LO) && (a <= lip_pkg::ADDR_IND_HI);
  endfunction

  // port k's own nibble: two ports per individual register, spare in 0x0e
  function automatic logic [3:0] own_code(input lip_ctl_s s, input int unsigned k);
    if (k == lip_pkg::SPARE_IDX) begin
      return s.eff_m[lip_pkg::GLOBAL_MSB:lip_pkg::GLOBAL_LSB];
    end
    return k[0] ? s.eff_ind[k / 2][7:lip_pkg::IND_HI_LSB] : s.eff_ind[k / 2][3:0];
  endfunction

  lip_timebase #(
    .STEP_CYC (STEP_CYC)
  ) lip_timebase_inst (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .run_i     (master_runs(q.eff_m)),
    .tk        (tk)
  );

  always_comb begin
    logic [3:0] code;
    logic       lit;
    code   = 4'h0;
    lit    = 1'b0;
    next_q = q;
    if (reg_wr_i && reg_addr_i == lip_pkg::ADDR_MASTER) begin
      next_q.mreg = reg_wdata_i;
    end
    if (reg_wr_i && ind_addr(reg_addr_i)) begin
      next_q.ind[reg_addr_i[2:0]] = reg_wdata_i;
    end
    if (reg_rd_i) begin
      if (reg_addr_i == lip_pkg::ADDR_MASTER) begin
        next_q.rdata = q.mreg;
      end else if (ind_addr(reg_addr_i)) begin
        next_q.rdata = q.ind[reg_addr_i[2:0]];
      end else begin
        next_q.rdata = 8'h00;
      end
    end
    // settings move to the working copy only at a period edge, or at once
    // while idle, so a write never truncates a pulse in flight
    // the first clock of a period still sees the old copy; sub 0 of slot 0
    // is lit for every code, so the late copy never shows on a pin
    if (!master_runs(q.eff_m) || tk.pstart) begin
      next_q.eff_m   = next_q.mreg;
      next_q.eff_ind = next_q.ind;
      next_q.eff_g   = global_en_i;
    end
    next_q.active = master_runs(q.eff_m);
    for (int unsigned k = 0; k < lip_pkg::NUM_OUT; k++) begin
      // one selection for all ports: no subset can be global
      code = q.eff_g ? q.eff_m[lip_pkg::GLOBAL_MSB:lip_pkg::GLOBAL_LSB] : own_code(q, k);
      if (!master_runs(q.eff_m) || code == lip_pkg::CODE_STATIC) begin
        lit = 1'b1;
      end else if (tk.slot < q.eff_m[lip_pkg::MASTER_MSB:lip_pkg::MASTER_LSB]) begin
        lit = (tk.sub <= code);
      end else begin
        lit = 1'b0;
      end
      // phase bit one inverts the duty and releases the pin when static
      next_q.oe[k] = lit ^ phase_bits_i[k];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q         <= '0;
      q.mreg    <= lip_pkg::MASTER_RESET;
      q.ind     <= {lip_pkg::NUM_IND_REG{lip_pkg::IND_RESET}};
      q.eff_m   <= lip_pkg::MASTER_RESET;
      q.eff_ind <= {lip_pkg::NUM_IND_REG{lip_pkg::IND_RESET}};
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata_o  = q.rdata;
  assign pwm_active_o = q.active;
  assign pin_out_o    = '0;
  assign pin_oe_o     = q.oe;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  logic [3:0] ind0;
  assign ind0 = q.eff_ind[0][3:0];

  sequence s_write_master_mid_period;
    reg_wr_i && reg_addr_i == lip_pkg::ADDR_MASTER && master_runs(q.eff_m) && !tk.pstart;
  endsequence

  sequence s_period_edge;
    tk.step ##0 tk.pstart;
  endsequence

  AST_MASTER_STORES: assert property (reg_wr_i && reg_addr_i == lip_pkg::ADDR_MASTER |=>
    q.mreg == $past(reg_wdata_i)) else $error("master register write not stored");
  AST_STATIC_ALL: assert property (!master_runs(q.eff_m) |=>
    pin_oe_o == ~$past(phase_bits_i)) else $error("static range still pwm");
  AST_GLOBAL_TOP: assert property (q.eff_g && q.eff_m[3:0] == 4'hf |=>
    pin_oe_o == ~$past(phase_bits_i)) else $error("global top code not static on all ports");
  AST_SPARE_OWN: assert property (!q.eff_g && q.eff_m[3:0] == 4'hf |=>
    pin_oe_o[16] == ~$past(phase_bits_i[16])) else $error("spare port ignores its nibble");
  AST_CODE_F: assert property (!q.eff_g && q.eff_ind[0][7:4] == 4'hf |=>
    pin_oe_o[1] == ~$past(phase_bits_i[1])) else $error("code f not static");
  AST_GATE_OFF: assert property (master_runs(q.eff_m) && !q.eff_g && ind0 != 4'hf
    && tk.slot >= q.eff_m[7:4] |=> pin_oe_o[0] == $past(phase_bits_i[0]))
    else $error("output active outside gated slots");
  AST_DUTY: assert property (master_runs(q.eff_m) && !q.eff_g && ind0 != 4'hf
    && tk.slot < q.eff_m[7:4] |=> pin_oe_o[0] == ($past(tk.sub <= ind0) ^ $past(phase_bits_i[0])))
    else $error("duty does not follow code");
  AST_HOLD_MID_PERIOD: assert property (s_write_master_mid_period |=>
    q.eff_m == $past(q.eff_m)) else $error("setting changed mid period");
  AST_PERIOD_EDGE: assert property (s_period_edge |-> tk.slot == 4'h0 && tk.sub == 4'h0)
    else $error("period start off position");
  AST_SLOT_RANGE: assert property (tk.slot <= 4'he) else $error("slot beyond 15");
  AST_IDLE: assert property (!master_runs(q.eff_m) ##1 !master_runs(q.eff_m) |->
    tk.sub == 4'h0 && tk.slot == 4'h0 && !tk.step) else $error("timebase runs while static");

  // port 2 and the global nibble, seen through the working copy
  logic [3:0] ind2;
  logic [3:0] gcode;
  assign ind2  = q.eff_ind[1][3:0];
  assign gcode = q.eff_m[lip_pkg::GLOBAL_MSB:lip_pkg::GLOBAL_LSB];

  sequence s_gated_slot;
    master_runs(q.eff_m) && tk.slot < q.eff_m[lip_pkg::MASTER_MSB:lip_pkg::MASTER_LSB];
  endsequence

  sequence s_read_master;
    reg_rd_i && reg_addr_i == lip_pkg::ADDR_MASTER;
  endsequence

  AST_PHASE_ONE_DUTY: assert property (s_gated_slot ##0 (!q.eff_g && ind2 != 4'hf && phase_bits_i[2])
    |=> pin_oe_o[2] == !$past(tk.sub <= ind2)) else $error("phase one duty not inverted");
  AST_GLOBAL_DUTY: assert property (s_gated_slot ##0 (q.eff_g && gcode != 4'hf) |=>
    pin_oe_o == ({17{$past(tk.sub <= gcode)}} ^ $past(phase_bits_i)))
    else $error("global duty differs between ports");
  AST_TOP_IGNORES_GATE: assert property (master_runs(q.eff_m) && !q.eff_g && q.eff_ind[0][7:4] == 4'hf
    && tk.slot >= q.eff_m[7:4] |=> pin_oe_o[1] == ~$past(phase_bits_i[1]))
    else $error("top code still gated");

  // register side: what a host read or write must leave behind
  AST_READ_MASTER: assert property (s_read_master |=> reg_rdata_o == $past(q.mreg))
    else $error("master register read back wrong");
  AST_READ_OTHER: assert property (reg_rd_i && reg_addr_i != lip_pkg::ADDR_MASTER && !ind_addr(reg_addr_i)
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  AST_IND_STORES: assert property (reg_wr_i && ind_addr(reg_addr_i) |=>
    q.ind[$past(reg_addr_i[2:0])] == $past(reg_wdata_i)) else $error("individual register write not stored");

  // the working copy follows the host copy exactly once per period
  AST_PERIOD_APPLY: assert property (s_period_edge |=> q.eff_m == q.mreg && q.eff_ind == q.ind
    && q.eff_g == $past(global_en_i)) else $error("setting not taken at period edge");
  // pwm flag tracks the working copy, one clock late
  AST_ACTIVE_ON: assert property (master_runs(q.eff_m) |=> pwm_active_o) else $error("pwm flag missing");
  AST_ACTIVE_OFF: assert property (!master_runs(q.eff_m) |=> !pwm_active_o) else $error("pwm flag stuck");
endmodule

// ---- dv/lip_host.sv ----
/*
  Host processor model: issues register writes and reads on the block's
  strobe interface, one request at a time.
  Assumes the block takes requests on the rising edge of ref_clk_i.
*/
`timescale 1ns/10ps
module lip_host (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // released lines show the inverse so a stale value is never mistaken for data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_o    = 1'b0;
    reg_addr_o  = ~a;
    reg_wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_o   = 1'b0;
    reg_addr_o = ~a;
    @(negedge ref_clk_i);
    d = reg_rdata_i;
  endtask
endmodule

// ---- dv/led_intensity_pwm_global_ctrl_bench.sv ----
/*
  Self-checking bench: host writes intensity settings, then the low time
  of each pin is counted over one full pwm period; pins 0, 1, 2 and 16 are compared.
  Assumes STEP_CYC of 4, so one period is 960 clocks.
*/
`timescale 1ns/10ps
module led_intensity_pwm_global_ctrl_bench;
  logic        ref_clk_i    = 1'b0;
  logic        rstn_i       = 1'b0;
  logic        global_en_i  = 1'b0;
  logic [16:0] phase_bits_i = 17'h00004;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  rd_val;
  logic        pwm_active;
  logic [16:0] pin_out;
  logic [16:0] pin_oe;
  int          n_fail       = 0;
  int          n_checks     = 0;

  always #4 ref_clk_i = ~ref_clk_i;

  lip_host lip_host_inst (
    .ref_clk_i   (ref_clk_i),
    .reg_rdata_i (reg_rdata),
    .reg_wr_o    (reg_wr),
    .reg_rd_o    (reg_rd),
    .reg_addr_o  (reg_addr),
    .reg_wdata_o (reg_wdata)
  );

  lip_pwm_ctrl #(.STEP_CYC(4)) lip_pwm_ctrl_inst (
    .ref_clk_i    (ref_clk_i),
    .rstn_i       (rstn_i),
    .reg_wr_i     (reg_wr),
    .reg_rd_i     (reg_rd),
    .reg_addr_i   (reg_addr),
    .reg_wdata_i  (reg_wdata),
    .global_en_i  (global_en_i),
    .phase_bits_i (phase_bits_i),
    .reg_rdata_o  (reg_rdata),
    .pwm_active_o (pwm_active),
    .pin_out_o    (pin_out),
    .pin_oe_o     (pin_oe)
  );

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // clocks driven low per 960-clock period; outside the gate the pin rests at the phase bit
  function automatic logic [16:0] low(input int code, input int ph, input int m);
    if (code == 15) begin
      return ph ? 17'h0 : 17'h3c0;
    end
    return 17'(m * (ph ? 15 - code : code + 1) * 4 + (15 - m) * 64 * ph);
  endfunction

  // port 2 has phase bit one, ports 0, 1 and 16 phase bit zero
  task automatic run(input int m, input int c0, input int c1, input int c2, input int c16);
    int cnt [17] = '{default: 0};
    repeat (960) begin
      @(negedge ref_clk_i);
      for (int i = 0; i < 17; i++) begin
        cnt[i] += (pin_oe[i] === 1'b1);
      end
    end
    check(17'(cnt[0]), low(c0, 0, m));
    check(17'(cnt[1]), low(c1, 0, m));
    check(17'(cnt[2]), low(c2, 1, m));
    check(17'(cnt[16]), low(c16, 0, m));
    check(pin_out, 17'h0);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check(pin_oe, ~phase_bits_i);
    check({16'h0, pwm_active}, 17'h0);
    lip_host_inst.rd(8'h0e, rd_val);
    check({9'h0, rd_val}, 17'h0);
    lip_host_inst.rd(8'h0f, rd_val);
    check({9'h0, rd_val}, 17'h0);
    lip_host_inst.wr(8'h10, 8'hf3);
    lip_host_inst.wr(8'h11, 8'h03);
    lip_host_inst.rd(8'h10, rd_val);
    check({9'h0, rd_val}, 17'h000f3);
    lip_host_inst.wr(8'h0e, 8'hf5);
    lip_host_inst.rd(8'h0e, rd_val);
    check({9'h0, rd_val}, 17'h000f5);
    repeat (1000) @(negedge ref_clk_i);
    check({16'h0, pwm_active}, 17'h1);
    run(15, 3, 15, 3, 5);
    lip_host_inst.wr(8'h0e, 8'h1f);
    repeat (1000) @(negedge ref_clk_i);
    run(1, 3, 15, 3, 15);
    global_en_i = 1'b1;
    lip_host_inst.wr(8'h0e, 8'h15);
    lip_host_inst.wr(8'h10, 8'h00);
    repeat (2000) @(negedge ref_clk_i);
    run(1, 5, 5, 5, 5);
    lip_host_inst.wr(8'h0e, 8'h0f);
    repeat (1000) @(negedge ref_clk_i);
    check(pin_oe, ~phase_bits_i);
    check({16'h0, pwm_active}, 17'h0);
    close_out();
  end
endmodule
